// >>> hdl/dlh_params.svh
// constants for the dc loop hold and current gain block
`ifndef DLH_PARAMS_SVH
`define DLH_PARAMS_SVH

`define DLH_CMD_CUR_GAIN 8'h2F
`define DLH_CMD_DC_CTRL 8'h30

`define DLH_GAIN_RESET 11'h400
`define DLH_GAIN_SHIFT 10
`define DLH_CTRL_RESET 16'h0000

`define DLH_BIT_FREQ_IDLE 15
`define DLH_BIT_UV_IDLE 14
`define DLH_THR_MSB 13
`define DLH_THR_LSB 7
`define DLH_BIT_PRD_EN 6
`define DLH_BIT_PHASE_EN 5
`define DLH_BIT_FB_EN 4
`define DLH_DUR_MSB 3
`define DLH_DUR_LSB 0

`define DLH_CLK_PERIOD_NS 40
`define DLH_HOLD_LSB_NS 100000
`define DLH_PRD_LSB_NS 80
`define DLH_HOLD_LSB_CYC ((`DLH_HOLD_LSB_NS + `DLH_CLK_PERIOD_NS - 1) / `DLH_CLK_PERIOD_NS)
`define DLH_PRD_LSB_CYC ((`DLH_PRD_LSB_NS + `DLH_CLK_PERIOD_NS - 1) / `DLH_CLK_PERIOD_NS)

`endif

// >>> hdl/dlh_pkg.sv
// types of the dc loop hold and current gain block
package dlh_pkg;

	typedef struct packed {
		logic freq_phase_add_idle_level;
		logic undervolt_phase_add_idle_level;
		logic [6:0] period_error_threshold;
		logic period_error_hold_enable;
		logic phase_change_hold_enable;
		logic feedback_window_hold_enable;
		logic [3:0] voltage_loop_hold_duration;
	} dlh_ctrl_s;

	typedef struct packed {
		logic freq_over_limit;
		logic feedback_low;
		logic feedback_high;
		logic period_qualify;
	} dlh_cond_s;

	typedef enum logic [0:0] {
		DLH_HOLD_IDLE,
		DLH_HOLD_RUN
	} dlh_hold_e;

endpackage

// >>> hdl/dlh_gain_mult.sv
// scales the raw current sample by the report gain
`timescale 1ns/1ps
`include "dlh_params.svh"
module dlh_gain_mult
	import dlh_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [15:0] raw_in,
	input wire logic raw_valid_in,
	input wire logic [10:0] gain_in,
	output logic [15:0] scaled_out,
	output logic scaled_valid_out
);
	logic [26:0] product;
	logic [16:0] quotient;
	logic [15:0] scaled_d;
	logic [15:0] scaled_q;
	logic valid_d;
	logic valid_q;

	always_comb begin
		product = 27'(raw_in) * 27'(gain_in);
		quotient = product[26:`DLH_GAIN_SHIFT];
		// gains above unity can overflow; clamp rather than wrap the report
		scaled_d = quotient[16] ? 16'hFFFF : quotient[15:0];
		valid_d = raw_valid_in;
		if (!raw_valid_in) begin
			scaled_d = scaled_q;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			scaled_q <= 16'h0000;
			valid_q <= 1'b0;
		end else begin
			scaled_q <= scaled_d;
			valid_q <= valid_d;
		end
	end

	assign scaled_out = scaled_q;
	assign scaled_valid_out = valid_q;
endmodule

// >>> hdl/dlh_hold_timer.sv
// retriggerable hold timer counted in 100 us steps
`timescale 1ns/1ps
`include "dlh_params.svh"
module dlh_hold_timer
	import dlh_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic trigger_in,
	input wire logic [3:0] duration_in,
	output logic active_out
);
	localparam logic [11:0] STEP_LAST = 12'(`DLH_HOLD_LSB_CYC - 1);

	dlh_hold_e state_d;
	dlh_hold_e state_q;
	logic [11:0] step_d;
	logic [11:0] step_q;
	logic [3:0] left_d;
	logic [3:0] left_q;

	always_comb begin
		state_d = state_q;
		step_d = step_q;
		left_d = left_q;
		case (state_q)
			DLH_HOLD_IDLE: begin
				step_d = STEP_LAST;
				left_d = 4'h0;
			end
			DLH_HOLD_RUN: begin
				if (step_q == 12'h000) begin
					step_d = STEP_LAST;
					left_d = left_q - 4'h1;
					if (left_q == 4'h1) begin
						state_d = DLH_HOLD_IDLE;
					end
				end else begin
					step_d = step_q - 12'h001;
				end
			end
			default: begin
				state_d = DLH_HOLD_IDLE;
			end
		endcase
		// a fresh trigger restarts the full hold; zero duration means no hold
		if (trigger_in && (duration_in != 4'h0)) begin
			state_d = DLH_HOLD_RUN;
			step_d = STEP_LAST;
			left_d = duration_in;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state_q <= DLH_HOLD_IDLE;
			step_q <= 12'h000;
			left_q <= 4'h0;
		end else begin
			state_q <= state_d;
			step_q <= step_d;
			left_q <= left_d;
		end
	end

	assign active_out = (state_q == DLH_HOLD_RUN);
endmodule

// >>> hdl/dlh_top.sv
// dc loop hold control and output current gain register bank
`timescale 1ns/1ps
`include "dlh_params.svh"
module dlh_top
	import dlh_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic cmd_wr_in,
	input wire logic cmd_rd_in,
	input wire logic [7:0] cmd_code_in,
	input wire logic [15:0] cmd_wdata_in,
	output logic [15:0] cmd_rdata_out,
	output logic cmd_rvalid_out,
	output logic cmd_nack_out,
	input wire logic [15:0] raw_current_in,
	input wire logic raw_current_valid_in,
	output logic [15:0] output_current_sense_out,
	output logic output_current_sense_valid_out,
	input wire logic auto_phase_shed_in,
	input wire logic freq_over_limit_in,
	input wire logic feedback_low_in,
	input wire logic feedback_high_in,
	input wire logic [15:0] period_measured_in,
	input wire logic [15:0] period_config_in,
	input wire logic pwm_limit_qualify_in,
	input wire logic [2:0] phase_count_in,
	output logic full_phase_ccm_out,
	output logic idle_pwm_high_out,
	output logic period_error_out,
	output logic cb_loop_hold_out,
	output logic dc_loop_hold_out,
	output logic dc_integrator_freeze_out,
	output logic [15:0] gain_reg_out,
	output logic [15:0] ctrl_reg_out
);
	function automatic logic cmd_mapped(input logic [7:0] code);
		cmd_mapped = (code == `DLH_CMD_CUR_GAIN) || (code == `DLH_CMD_DC_CTRL);
	endfunction

	// register bank
	logic [10:0] gain_d;
	logic [10:0] gain_q;
	dlh_ctrl_s ctrl_d;
	dlh_ctrl_s ctrl_q;
	logic [15:0] rdata_d;
	logic [15:0] rdata_q;
	logic rvalid_d;
	logic rvalid_q;
	logic nack_d;
	logic nack_q;

	always_comb begin
		gain_d = gain_q;
		ctrl_d = ctrl_q;
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		nack_d = 1'b0;
		if (cmd_wr_in) begin
			if (cmd_code_in == `DLH_CMD_CUR_GAIN) begin
				gain_d = cmd_wdata_in[10:0];
			end
			if (cmd_code_in == `DLH_CMD_DC_CTRL) begin
				ctrl_d = dlh_ctrl_s'(cmd_wdata_in);
			end
			nack_d = !cmd_mapped(cmd_code_in);
		end
		if (cmd_rd_in) begin
			rvalid_d = cmd_mapped(cmd_code_in);
			nack_d = !cmd_mapped(cmd_code_in);
			case (cmd_code_in)
				`DLH_CMD_CUR_GAIN: begin
					rdata_d = {5'h00, gain_q};
				end
				`DLH_CMD_DC_CTRL: begin
					rdata_d = 16'(ctrl_q);
				end
				default: begin
					rdata_d = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			gain_q <= `DLH_GAIN_RESET;
			ctrl_q <= dlh_ctrl_s'(`DLH_CTRL_RESET);
			rdata_q <= 16'h0000;
			rvalid_q <= 1'b0;
			nack_q <= 1'b0;
		end else begin
			gain_q <= gain_d;
			ctrl_q <= ctrl_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			nack_q <= nack_d;
		end
	end

	// current report path
	dlh_gain_mult u_gain (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.raw_in(raw_current_in),
		.raw_valid_in(raw_current_valid_in),
		.gain_in(gain_q),
		.scaled_out(output_current_sense_out),
		.scaled_valid_out(output_current_sense_valid_out)
	);

	// phase add on load step
	logic ccm_d;
	logic ccm_q;
	logic idle_high_d;
	logic idle_high_q;

	always_comb begin
		ccm_d = 1'b0;
		idle_high_d = idle_high_q;
		if (auto_phase_shed_in) begin
			// frequency cause wins when both arrive together
			if (freq_over_limit_in) begin
				ccm_d = 1'b1;
				idle_high_d = ctrl_q.freq_phase_add_idle_level;
			end else if (feedback_low_in) begin
				ccm_d = 1'b1;
				idle_high_d = ctrl_q.undervolt_phase_add_idle_level;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			ccm_q <= 1'b0;
			idle_high_q <= 1'b0;
		end else begin
			ccm_q <= ccm_d;
			idle_high_q <= idle_high_d;
		end
	end

	// period error and hold triggers
	logic [15:0] period_dev;
	logic [15:0] thr_cycles;
	logic perr_d;
	logic perr_q;
	logic [2:0] phase_d;
	logic [2:0] phase_q;
	logic phase_seen_d;
	logic phase_seen_q;
	logic dc_trigger;

	always_comb begin
		if (period_measured_in >= period_config_in) begin
			period_dev = period_measured_in - period_config_in;
		end else begin
			period_dev = period_config_in - period_measured_in;
		end
		thr_cycles = 16'(ctrl_q.period_error_threshold) * 16'(`DLH_PRD_LSB_CYC);
		perr_d = (period_dev > thr_cycles);
		phase_d = phase_count_in;
		phase_seen_d = 1'b1;
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			perr_q <= 1'b0;
			phase_q <= 3'h0;
			phase_seen_q <= 1'b0;
		end else begin
			perr_q <= perr_d;
			phase_q <= phase_d;
			phase_seen_q <= phase_seen_d;
		end
	end

	// first sample after reset only primes the phase compare
	assign dc_trigger =
		(ctrl_q.period_error_hold_enable && perr_q && pwm_limit_qualify_in) ||
		(ctrl_q.phase_change_hold_enable && phase_seen_q && (phase_q != phase_count_in)) ||
		(ctrl_q.feedback_window_hold_enable && (feedback_low_in || feedback_high_in));

	logic hold_active;

	dlh_hold_timer u_hold (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.trigger_in(dc_trigger),
		.duration_in(ctrl_q.voltage_loop_hold_duration),
		.active_out(hold_active)
	);

	logic cb_hold_d;
	logic cb_hold_q;
	logic dc_hold_d;
	logic dc_hold_q;

	always_comb begin
		cb_hold_d = perr_q;
		// the period hold is immediate; the timed hold covers the rest
		dc_hold_d = hold_active || (perr_q && ctrl_q.period_error_hold_enable
			&& pwm_limit_qualify_in);
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			cb_hold_q <= 1'b0;
			dc_hold_q <= 1'b0;
		end else begin
			cb_hold_q <= cb_hold_d;
			dc_hold_q <= dc_hold_d;
		end
	end

	assign cmd_rdata_out = rdata_q;
	assign cmd_rvalid_out = rvalid_q;
	assign cmd_nack_out = nack_q;
	assign full_phase_ccm_out = ccm_q;
	assign idle_pwm_high_out = idle_high_q;
	assign period_error_out = perr_q;
	assign cb_loop_hold_out = cb_hold_q;
	assign dc_loop_hold_out = dc_hold_q;
	assign dc_integrator_freeze_out = dc_hold_q;
	assign gain_reg_out = {5'h00, gain_q};
	assign ctrl_reg_out = 16'(ctrl_q);
endmodule

// >>> tb/dlh_checker.sv
// assertion checker for the dc loop hold block
`timescale 1ns/1ps
module dlh_checker
	import dlh_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [15:0] raw_current_in,
	input wire logic raw_current_valid_in,
	input wire logic [15:0] output_current_sense_out,
	input wire logic auto_phase_shed_in,
	input wire logic freq_over_limit_in,
	input wire logic feedback_low_in,
	input wire logic feedback_high_in,
	input wire logic [15:0] period_measured_in,
	input wire logic [15:0] period_config_in,
	input wire logic pwm_limit_qualify_in,
	input wire logic [2:0] phase_count_in,
	input wire logic full_phase_ccm_out,
	input wire logic idle_pwm_high_out,
	input wire logic period_error_out,
	input wire logic dc_loop_hold_out,
	input wire logic [15:0] gain_reg_out,
	input wire logic [15:0] ctrl_reg_out
);
	logic [26:0] prod;
	logic [15:0] dif;
	logic over;
	assign prod = 27'(raw_current_in) * 27'(gain_reg_out[10:0]);
	// deviation either way counts
	assign dif = period_measured_in > period_config_in ? period_measured_in - period_config_in
		: period_config_in - period_measured_in;
	assign over = dif > 16'({ctrl_reg_out[13:7], 1'b0});
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	// zero duration means no timed hold
	sequence s_fb;
		ctrl_reg_out[4] && ctrl_reg_out[3:0] != 4'h0 && (feedback_low_in || feedback_high_in);
	endsequence
	sequence s_held;
		dc_loop_hold_out [*8];
	endsequence
	AST_GAIN_RST: assert property ($fell(rst_in) |-> gain_reg_out == 16'h0400)
		else $error("gain reset value wrong");
	AST_GAIN_TOP: assert property (gain_reg_out[15:11] == 5'h00)
		else $error("gain upper bits set");
	AST_SCALE: assert property (raw_current_valid_in |=> output_current_sense_out ==
		($past(prod[26]) ? 16'hFFFF : $past(prod[25:10]))) else $error("scaled current wrong");
	AST_CCM: assert property (auto_phase_shed_in && (freq_over_limit_in || feedback_low_in)
		|=> full_phase_ccm_out) else $error("full phase not entered");
	AST_IDLE: assert property (auto_phase_shed_in && freq_over_limit_in
		|=> idle_pwm_high_out == $past(ctrl_reg_out[15])) else $error("idle level wrong");
	AST_IDLE_UV: assert property (auto_phase_shed_in && !freq_over_limit_in && feedback_low_in
		|=> idle_pwm_high_out == $past(ctrl_reg_out[14])) else $error("undervolt idle level wrong");
	AST_PERR: assert property (period_error_out == $past(over))
		else $error("period error wrong");
	AST_PRD: assert property (period_error_out && ctrl_reg_out[6] && pwm_limit_qualify_in
		|=> dc_loop_hold_out) else $error("period hold missing");
	AST_FB: assert property (s_fb |-> ##2 s_held)
		else $error("feedback hold missing");
	AST_PHASE: assert property (ctrl_reg_out[5] && ctrl_reg_out[3:0] != 4'h0
		&& phase_count_in != $past(phase_count_in) |-> ##2 s_held) else $error("phase hold missing");
endmodule

bind dlh_top dlh_checker u_chk(.sys_clk_in, .rst_in, .raw_current_in, .raw_current_valid_in,
	.output_current_sense_out, .auto_phase_shed_in, .freq_over_limit_in, .feedback_low_in,
	.feedback_high_in, .period_measured_in, .period_config_in, .pwm_limit_qualify_in,
	.phase_count_in, .full_phase_ccm_out, .idle_pwm_high_out, .period_error_out,
	.dc_loop_hold_out, .gain_reg_out, .ctrl_reg_out);

// >>> tb/dlh_host.sv
// management bus host model on the command port
`timescale 1ns/1ps
module dlh_host (
	input wire logic sys_clk_in,
	input wire logic [15:0] rdata_in,
	input wire logic rvalid_in,
	input wire logic nack_in,
	output logic wr_out = 1'b0,
	output logic rd_out = 1'b0,
	output logic [7:0] code_out = 8'h00,
	output logic [15:0] wdata_out = 16'h0000
);
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(negedge sys_clk_in);
		code_out = c;
		wdata_out = d;
		wr_out = 1'b1;
		@(negedge sys_clk_in);
		wr_out = 1'b0;
		// released lines must not keep the old value
		code_out = ~c;
		wdata_out = ~d;
	endtask
	task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic [1:0] r);
		@(negedge sys_clk_in);
		code_out = c;
		rd_out = 1'b1;
		@(negedge sys_clk_in);
		rd_out = 1'b0;
		code_out = ~c;
		d = rdata_in;
		r = {rvalid_in, nack_in};
	endtask
endmodule

// >>> tb/dc_loop_hold_and_current_gain_test.sv
// self-checking testbench for the dc loop hold block
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
	$display("BAD %0t %h %h", $time, a, b); end end
module dc_loop_hold_and_current_gain_test;
	logic sys_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic cmd_wr_in, cmd_rd_in, cmd_rvalid_out, cmd_nack_out, raw_current_valid_in;
	logic output_current_sense_valid_out, auto_phase_shed_in, freq_over_limit_in;
	logic feedback_low_in, feedback_high_in, pwm_limit_qualify_in, full_phase_ccm_out;
	logic idle_pwm_high_out, period_error_out, cb_loop_hold_out, dc_loop_hold_out;
	logic dc_integrator_freeze_out;
	logic [7:0] cmd_code_in;
	logic [15:0] cmd_wdata_in, cmd_rdata_out, raw_current_in, output_current_sense_out;
	logic [15:0] period_measured_in, period_config_in, gain_reg_out, ctrl_reg_out, d;
	logic [2:0] phase_count_in;
	logic [1:0] r;
	int mismatches = 0;
	int n_tests = 0;
	int len;
	always #20 sys_clk_in = ~sys_clk_in;
	dlh_top u_dut(.sys_clk_in, .rst_in, .cmd_wr_in, .cmd_rd_in, .cmd_code_in, .cmd_wdata_in,
		.cmd_rdata_out, .cmd_rvalid_out, .cmd_nack_out, .raw_current_in, .raw_current_valid_in,
		.output_current_sense_out, .output_current_sense_valid_out, .auto_phase_shed_in,
		.freq_over_limit_in, .feedback_low_in, .feedback_high_in, .period_measured_in,
		.period_config_in, .pwm_limit_qualify_in, .phase_count_in, .full_phase_ccm_out,
		.idle_pwm_high_out, .period_error_out, .cb_loop_hold_out, .dc_loop_hold_out,
		.dc_integrator_freeze_out, .gain_reg_out, .ctrl_reg_out);
	dlh_host u_host(.sys_clk_in, .rdata_in(cmd_rdata_out), .rvalid_in(cmd_rvalid_out),
		.nack_in(cmd_nack_out), .wr_out(cmd_wr_in), .rd_out(cmd_rd_in),
		.code_out(cmd_code_in), .wdata_out(cmd_wdata_in));
	task automatic cur(input logic [15:0] v, input logic [15:0] e);
		@(negedge sys_clk_in);
		raw_current_in = v;
		raw_current_valid_in = 1'b1;
		@(negedge sys_clk_in);
		raw_current_valid_in = 1'b0;
		raw_current_in = ~v;
		`CHK(output_current_sense_out, e)
		`CHK(output_current_sense_valid_out, 1'b1)
	endtask
	task automatic hold_len(output int n);
		n = 0;
		repeat (3) @(negedge sys_clk_in);
		while (dc_loop_hold_out === 1'b1 && n < 40000) begin
			@(negedge sys_clk_in);
			n++;
		end
	endtask
	task automatic fb_pulse();
		@(negedge sys_clk_in);
		feedback_high_in = 1'b1;
		@(negedge sys_clk_in);
		feedback_high_in = 1'b0;
	endtask
	task automatic t_regs();
		cur(16'hABCD, 16'hABCD);
		u_host.rd(8'h2F, d, r);
		`CHK({d, r}, {16'h0400, 2'b10})
		u_host.wr(8'h2F, 16'hFA00);
		u_host.rd(8'h2F, d, r);
		`CHK(d, 16'h0200)
		cur(16'h1234, 16'h091A);
		u_host.wr(8'h2F, 16'h07FF);
		cur(16'hFFFF, 16'hFFFF);
		u_host.wr(8'h31, 16'h0123);
		`CHK(cmd_nack_out, 1'b1)
		u_host.rd(8'h2F, d, r);
		`CHK({d, r}, {16'h07FF, 2'b10})
		u_host.rd(8'h31, d, r);
		`CHK({d, r}, {16'h0000, 2'b01})
	endtask
	task automatic t_mode();
		u_host.wr(8'h30, 16'h8000);
		auto_phase_shed_in = 1'b1;
		freq_over_limit_in = 1'b1;
		@(negedge sys_clk_in);
		`CHK({full_phase_ccm_out, idle_pwm_high_out}, 2'b11)
		u_host.wr(8'h30, 16'h0000);
		freq_over_limit_in = 1'b0;
		feedback_low_in = 1'b1;
		@(negedge sys_clk_in);
		`CHK({full_phase_ccm_out, idle_pwm_high_out}, 2'b10)
		u_host.wr(8'h30, 16'h4000);
		@(negedge sys_clk_in);
		`CHK(idle_pwm_high_out, 1'b1)
		auto_phase_shed_in = 1'b0;
		feedback_low_in = 1'b0;
		@(negedge sys_clk_in);
		`CHK(full_phase_ccm_out, 1'b0)
	endtask
	task automatic t_hold();
		u_host.wr(8'h30, 16'h0001);
		fb_pulse();
		hold_len(len);
		`CHK(len, 0)
		`CHK(dc_loop_hold_out, 1'b0)
		u_host.wr(8'h30, 16'h0011);
		fb_pulse();
		repeat (1000) @(negedge sys_clk_in);
		fb_pulse();
		hold_len(len);
		`CHK(len > 2494 && len < 2503, 1'b1)
		u_host.wr(8'h30, 16'h0021);
		phase_count_in = 3'h5;
		hold_len(len);
		`CHK(len > 2494 && len < 2503, 1'b1)
	endtask
	task automatic t_period();
		u_host.wr(8'h30, 16'h0141);
		period_measured_in = 16'd104;
		repeat (3) @(negedge sys_clk_in);
		`CHK({period_error_out, cb_loop_hold_out}, 2'b00)
		period_measured_in = 16'd95;
		repeat (3) @(negedge sys_clk_in);
		`CHK({period_error_out, cb_loop_hold_out, dc_loop_hold_out}, 3'b110)
		pwm_limit_qualify_in = 1'b1;
		repeat (3) @(negedge sys_clk_in);
		`CHK(dc_loop_hold_out, 1'b1)
		`CHK(dc_integrator_freeze_out, 1'b1)
		period_measured_in = 16'd100;
		pwm_limit_qualify_in = 1'b0;
		hold_len(len);
		`CHK(len > 2494 && len < 2503, 1'b1)
		u_host.rd(8'h30, d, r);
		`CHK({d, r}, {16'h0141, 2'b10})
	endtask
	task automatic t_reset();
		@(negedge sys_clk_in);
		rst_in = 1'b1;
		repeat (2) @(negedge sys_clk_in);
		rst_in = 1'b0;
		`CHK({gain_reg_out, ctrl_reg_out, dc_loop_hold_out}, {16'h0400, 16'h0000, 1'b0})
		u_host.rd(8'h2F, d, r);
		`CHK({d, r}, {16'h0400, 2'b10})
	endtask
	task automatic print_verdict();
		if (mismatches == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		{raw_current_in, raw_current_valid_in, auto_phase_shed_in, freq_over_limit_in} = '0;
		{feedback_low_in, feedback_high_in, pwm_limit_qualify_in, phase_count_in} = '0;
		period_config_in = 16'd100;
		period_measured_in = 16'd100;
		repeat (6) @(negedge sys_clk_in);
		rst_in = 1'b0;
		t_regs();
		t_mode();
		t_hold();
		t_period();
		t_reset();
		print_verdict();
	end
	// runs take about 9k cycles
	initial begin
		#(40 * 30000);
		mismatches++;
		print_verdict();
	end
endmodule
